/* core/msp_params.svh */
/*
 Constants of the motion sensor path block: register indexes, field
 positions, reset values and timing figures.
 Assumes it is included by bare name wherever these are needed.
*/
`ifndef MSP_PARAMS_SVH
`define MSP_PARAMS_SVH

// register indexes; the wishbone byte address is four times the index
`define MSP_IDX_RATE_DIV     8'h19
`define MSP_IDX_FILTER_SYNC  8'h1A
`define MSP_IDX_ROT_RANGE    8'h1B
`define MSP_IDX_TILT_SETUP   8'h1C
`define MSP_IDX_FALL_THR     8'h1D
`define MSP_IDX_FALL_DUR     8'h1E
`define MSP_IDX_STATUS       8'h40

// field positions and masks of writable bits
`define MSP_LOWPASS_LSB      0
`define MSP_SYNC_SEL_LSB     3
`define MSP_ROT_RANGE_LSB    3
`define MSP_TILT_RANGE_LSB   3
`define MSP_HPF_LSB          0
`define MSP_SELFTEST_LSB     5
`define MSP_FILTER_MASK      8'h3F
`define MSP_ROT_MASK         8'h18
`define MSP_TILT_MASK        8'hFF
`define MSP_REG_RESET        8'h00

// status bits
`define MSP_ST_FALL_STICKY   0
`define MSP_ST_FALL_NOW      1
`define MSP_ST_SYNC_SAMPLE   2
`define MSP_ST_GYRO_FAST     3

// timing: figures in their own unit, counts derived from the clock
`define MSP_CLK_HZ           25000000
`define MSP_GYRO_FAST_HZ     8000
`define MSP_GYRO_SLOW_HZ     1000
`define MSP_FALL_TICK_HZ     1000
`define MSP_FAST_CYCLES      (`MSP_CLK_HZ / `MSP_GYRO_FAST_HZ)
`define MSP_MS_CYCLES        (`MSP_CLK_HZ / `MSP_FALL_TICK_HZ)

`endif

/* core/msp_pkg.sv */
/*
 Types shared by the motion sensor path block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package msp_pkg;

   // decoded high-pass mode; codes 5 and 6 fall back to reset
   typedef enum logic [1:0] {
      MSP_HPF_RESET,
      MSP_HPF_ON,
      MSP_HPF_HOLD
   } msp_hpf_mode_t;

   typedef logic signed [16:0] msp_wide_t;

endpackage

/* core/msp_hpf.sv */
/*
 One axis of the high-pass filter in the detector path.
 Assumes step_i is a one-cycle pulse at the sample rate.
*/
`timescale 1ns/1ps
`default_nettype none

module msp_hpf (
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   input  wire logic                    step_i,
   input  wire logic [2:0]              mode_i,
   input  wire logic signed [15:0]      sample_i,
   output logic      signed [16:0]      out_o
);

   msp_pkg::msp_hpf_mode_t mode;
   msp_pkg::msp_wide_t     diff;
   logic signed [16:0]     base_reg;
   logic                   was_hold_reg;
   logic [2:0]             shift;

   // ----------------------------------------------------------------
   // mode decode and cut-off shift
   // ----------------------------------------------------------------
   always_comb begin
      case (mode_i)
         3'h0:    mode = msp_pkg::MSP_HPF_RESET;
         3'h7:    mode = msp_pkg::MSP_HPF_HOLD;
         3'h5,
         3'h6:    mode = msp_pkg::MSP_HPF_RESET;
         default: mode = msp_pkg::MSP_HPF_ON;
      endcase
      // a larger shift lowers the cut-off: 5, 2.5, 1.25, 0.63 Hz
      shift = 3'(mode_i) + 3'h2;
      diff  = 17'(sample_i) - base_reg;
   end

   // ----------------------------------------------------------------
   // filter state and output, stepped once per sample
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         base_reg     <= '0;
         was_hold_reg <= 1'b0;
         out_o        <= '0;
      end else if (step_i) begin
         was_hold_reg <= (mode == msp_pkg::MSP_HPF_HOLD);
         case (mode)
            msp_pkg::MSP_HPF_RESET: begin
               base_reg <= 17'(sample_i);                        // R11
               out_o    <= '0;                                   // R11
            end
            msp_pkg::MSP_HPF_ON: begin
               base_reg <= base_reg + (diff >>> shift);          // R10
               out_o    <= diff;                                 // R10
            end
            msp_pkg::MSP_HPF_HOLD: begin
               if (!was_hold_reg) begin
                  base_reg <= 17'(sample_i);                     // R13
                  out_o    <= '0;
               end else begin
                  out_o    <= diff;                              // R13
               end
            end
            default: out_o <= '0;
         endcase
      end
   end

endmodule // msp_hpf

`default_nettype wire

/* core/msp_top.sv */
/*
 Signal path configuration and free-fall logic of a rotation-rate and
 acceleration sensor, reached over a classic wishbone slave.
 Assumes sensor samples and the frame-sync input are synchronous to
 clk_i; the data-byte outputs here are what the data registers show.
*/
// The implementer's own choice: register access over Wishbone.
// What this block does
// R1 - latch frame-sync changes, catch short pulses
// R2 - sample latch per tick, then reload level
// R3 - sync select places sampled bit in bit0
// R4 - gyro rate 8k for codes 0,7
// R5 - lowpass codes narrow bandwidth; code 7 reserved
// R6 - two-bit gyro full-scale range select
// R7 - two-bit accel full-scale range select
// R8 - per-axis self-test bits act independently
// R9 - high-pass output feeds detectors only
// R10 - high-pass mode decode: reset, on, hold
// R11 - reset mode drives filter output zero
// R12 - software may pulse reset mode to settle
// R13 - hold stores sample, outputs difference
// R14 - free fall when all axes below threshold
// R15 - counter counts free fall, fires at duration
// R16 - duration counter ticks once per millisecond
// R17 - sample tick is gyro rate over divider+1
// R18 - configuration registers reset to zero
// R19 - counter clears when any axis reaches threshold
// R20 - reserved bits ignore writes, read zero
`timescale 1ns/1ps
`default_nettype none
`include "msp_params.svh"

module msp_top #(
   parameter int FAST_CYCLES = `MSP_FAST_CYCLES,
   parameter int MS_CYCLES   = `MSP_MS_CYCLES
) (
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire logic               wb_cyc_i,
   input  wire logic               wb_stb_i,
   input  wire logic               wb_we_i,
   input  wire logic [9:0]         wb_adr_i,
   input  wire logic [3:0]         wb_sel_i,
   input  wire logic [31:0]        wb_dat_i,
   output logic      [31:0]        wb_dat_o,
   output logic                    wb_ack_o,
   input  wire logic               frame_sync_in_i,
   input  wire logic [7:0]         temp_low_raw_i,
   input  wire logic [7:0]         rotation_x_raw_i,
   input  wire logic [7:0]         rotation_y_raw_i,
   input  wire logic [7:0]         rotation_z_raw_i,
   input  wire logic signed [15:0] tilt_x_raw_i,
   input  wire logic signed [15:0] tilt_y_raw_i,
   input  wire logic signed [15:0] tilt_z_raw_i,
   output logic      [7:0]         temp_low_byte_o,
   output logic      [7:0]         rotation_x_low_byte_o,
   output logic      [7:0]         rotation_y_low_byte_o,
   output logic      [7:0]         rotation_z_low_byte_o,
   output logic      [7:0]         tilt_x_low_byte_o,
   output logic      [7:0]         tilt_y_low_byte_o,
   output logic      [7:0]         tilt_z_low_byte_o,
   output logic      [2:0]         lowpass_setting_o,
   output logic      [1:0]         rotation_range_sel_o,
   output logic      [1:0]         tilt_range_sel_o,
   output logic      [2:0]         axis_selftest_o,
   output logic                    sample_tick_o,
   output logic                    free_fall_event_o
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [7:0]  rate_divider_reg;
   logic [7:0]  filter_sync_setup_reg;
   logic [7:0]  rotation_range_setup_reg;
   logic [7:0]  tilt_range_selftest_setup_reg;
   logic [7:0]  fall_threshold_reg;
   logic [7:0]  fall_duration_reg;
   logic        fall_sticky_reg;
   logic [11:0] fast_cnt_reg;
   logic [15:0] ms_cnt_reg;
   logic [7:0]  div_cnt_reg;
   logic        fast_tick;
   logic        ms_tick;
   logic        gyro_fast;
   logic        gyro_tick;
   logic        sample_tick;
   logic        sync_latch_reg;
   logic        sync_sample_reg;
   logic [2:0]  sync_bit_select;
   logic [2:0]  highpass_mode;
   logic [7:0]  fall_cnt_reg;
   logic        fall_cond;
   logic        bus_req;
   logic        bus_wr;
   logic [7:0]  bus_idx;
   logic [7:0]  rd_data;
   logic [7:0]  raw_low   [7];
   logic [7:0]  data_reg  [7];
   logic signed [15:0] tilt_raw [3];
   logic signed [16:0] hpf_out  [3];
   logic [2:0]  axis_below;

   assign sync_bit_select = filter_sync_setup_reg[`MSP_SYNC_SEL_LSB +: 3];
   assign lowpass_setting_o =
      filter_sync_setup_reg[`MSP_LOWPASS_LSB +: 3];                  // R5
   assign rotation_range_sel_o =
      rotation_range_setup_reg[`MSP_ROT_RANGE_LSB +: 2];             // R6
   assign tilt_range_sel_o =
      tilt_range_selftest_setup_reg[`MSP_TILT_RANGE_LSB +: 2];       // R7
   // each bit drives its own axis; no bit gates another
   assign axis_selftest_o =
      tilt_range_selftest_setup_reg[`MSP_SELFTEST_LSB +: 3];         // R8
   assign highpass_mode = tilt_range_selftest_setup_reg[`MSP_HPF_LSB +: 3];

   // ----------------------------------------------------------------
   // wishbone slave: one wait state, ack for one cycle
   // ----------------------------------------------------------------
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign bus_wr  = bus_req && wb_we_i && wb_sel_i[0];
   assign bus_idx = wb_adr_i[9:2];

   // registers take the write at the edge the request is first seen
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rate_divider_reg              <= `MSP_REG_RESET;        // R18
         filter_sync_setup_reg         <= `MSP_REG_RESET;        // R18
         rotation_range_setup_reg      <= `MSP_REG_RESET;        // R18
         tilt_range_selftest_setup_reg <= `MSP_REG_RESET;        // R18
         fall_threshold_reg            <= `MSP_REG_RESET;        // R18
         fall_duration_reg             <= `MSP_REG_RESET;        // R18
      end else if (bus_wr) begin
         case (bus_idx)
            `MSP_IDX_RATE_DIV:    rate_divider_reg <= wb_dat_i[7:0];
            `MSP_IDX_FILTER_SYNC: filter_sync_setup_reg <=
               wb_dat_i[7:0] & `MSP_FILTER_MASK;                 // R20
            `MSP_IDX_ROT_RANGE:   rotation_range_setup_reg <=
               wb_dat_i[7:0] & `MSP_ROT_MASK;                    // R20
            `MSP_IDX_TILT_SETUP:  tilt_range_selftest_setup_reg <=
               wb_dat_i[7:0] & `MSP_TILT_MASK;
            `MSP_IDX_FALL_THR:    fall_threshold_reg <= wb_dat_i[7:0];
            `MSP_IDX_FALL_DUR:    fall_duration_reg <= wb_dat_i[7:0];
            default: ;
         endcase
      end
   end

   // read mux; unmapped indexes read zero and still get an ack
   always_comb begin
      case (bus_idx)
         `MSP_IDX_RATE_DIV:    rd_data = rate_divider_reg;
         `MSP_IDX_FILTER_SYNC: rd_data = filter_sync_setup_reg;
         `MSP_IDX_ROT_RANGE:   rd_data = rotation_range_setup_reg;
         `MSP_IDX_TILT_SETUP:  rd_data = tilt_range_selftest_setup_reg;
         `MSP_IDX_FALL_THR:    rd_data = fall_threshold_reg;
         `MSP_IDX_FALL_DUR:    rd_data = fall_duration_reg;
         `MSP_IDX_STATUS:      rd_data = {4'h0, gyro_fast,
                                  sync_sample_reg, fall_cond,
                                  fall_sticky_reg};
         default:              rd_data = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= bus_req ? {24'h00_0000, rd_data} : 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // rate generation: 8 kHz, 1 kHz and the divided sample tick
   // ----------------------------------------------------------------
   assign fast_tick = (fast_cnt_reg == 12'(FAST_CYCLES - 1));
   assign ms_tick   = (ms_cnt_reg == 16'(MS_CYCLES - 1));
   // lowpass bypassed (codes 0 and 7) runs the gyro at 8 kHz
   assign gyro_fast = (lowpass_setting_o == 3'h0) ||
                      (lowpass_setting_o == 3'h7);                   // R4
   assign gyro_tick = gyro_fast ? fast_tick : ms_tick;               // R4
   assign sample_tick = gyro_tick && (div_cnt_reg == rate_divider_reg);
   assign sample_tick_o = sample_tick;

   always_ff @(posedge clk_i) begin
      if (rst_i || fast_tick) fast_cnt_reg <= 12'h000;
      else fast_cnt_reg <= fast_cnt_reg + 12'h001;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || ms_tick) ms_cnt_reg <= 16'h0000;                  // R16
      else ms_cnt_reg <= ms_cnt_reg + 16'h0001;
   end

   // a divider rewritten below the count restarts at the next wrap
   always_ff @(posedge clk_i) begin
      if (rst_i) div_cnt_reg <= 8'h00;
      else if (sample_tick) div_cnt_reg <= 8'h00;                    // R17
      else if (gyro_tick) div_cnt_reg <= div_cnt_reg + 8'h01;        // R17
   end

   // ----------------------------------------------------------------
   // frame-sync latch and sample
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync_latch_reg  <= 1'b0;
         sync_sample_reg <= 1'b0;
      end else if (sample_tick) begin
         sync_sample_reg <= sync_latch_reg | frame_sync_in_i;        // R2
         sync_latch_reg  <= frame_sync_in_i;                         // R2
      end else if (frame_sync_in_i) begin
         sync_latch_reg  <= 1'b1;                                    // R1
      end
   end

   // ----------------------------------------------------------------
   // data bytes: raw values, never high-passed, sync bit in bit 0
   // ----------------------------------------------------------------
   assign raw_low[0] = temp_low_raw_i;
   assign raw_low[1] = rotation_x_raw_i;
   assign raw_low[2] = rotation_y_raw_i;
   assign raw_low[3] = rotation_z_raw_i;
   assign raw_low[4] = tilt_x_raw_i[7:0];                            // R9
   assign raw_low[5] = tilt_y_raw_i[7:0];                            // R9
   assign raw_low[6] = tilt_z_raw_i[7:0];                            // R9

   // the sync bit uses the value sampled at the same tick
   genvar gi;
   generate
      for (gi = 0; gi < 7; gi++) begin : g_data
         always_ff @(posedge clk_i) begin
            if (rst_i) data_reg[gi] <= 8'h00;
            else if (sample_tick) begin
               if (sync_bit_select == 3'(gi + 1))                    // R3
                  data_reg[gi] <= {raw_low[gi][7:1],
                                   sync_latch_reg | frame_sync_in_i};
               else
                  data_reg[gi] <= raw_low[gi];
            end
         end
      end
   endgenerate

   assign temp_low_byte_o       = data_reg[0];
   assign rotation_x_low_byte_o = data_reg[1];
   assign rotation_y_low_byte_o = data_reg[2];
   assign rotation_z_low_byte_o = data_reg[3];
   assign tilt_x_low_byte_o     = data_reg[4];
   assign tilt_y_low_byte_o     = data_reg[5];
   assign tilt_z_low_byte_o     = data_reg[6];

   // ----------------------------------------------------------------
   // high-pass path and free-fall compare per axis
   // ----------------------------------------------------------------
   assign tilt_raw[0] = tilt_x_raw_i;
   assign tilt_raw[1] = tilt_y_raw_i;
   assign tilt_raw[2] = tilt_z_raw_i;

   // threshold lsb weighs 256 sample lsbs, so 8 bits span full scale
   generate
      for (gi = 0; gi < 3; gi++) begin : g_axis
         msp_hpf msp_hpf_i (
            .clk_i    (clk_i),
            .rst_i    (rst_i),
            .step_i   (sample_tick),
            .mode_i   (highpass_mode),
            .sample_i (tilt_raw[gi]),
            .out_o    (hpf_out[gi])
         );
         assign axis_below[gi] =
            ((hpf_out[gi][16] ? 17'(-hpf_out[gi]) : hpf_out[gi])
             < {1'b0, fall_threshold_reg, 8'h00});                   // R14
      end
   endgenerate

   assign fall_cond = &axis_below;                                   // R14

   // ----------------------------------------------------------------
   // free-fall duration counter and event
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) fall_cnt_reg <= 8'h00;
      else if (ms_tick) begin                                        // R16
         if (!fall_cond) fall_cnt_reg <= 8'h00;                      // R19
         else if (fall_cnt_reg != 8'hFF)
            fall_cnt_reg <= fall_cnt_reg + 8'h01;                    // R15
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) free_fall_event_o <= 1'b0;
      else free_fall_event_o <= ms_tick && fall_cond &&
         (fall_duration_reg != 8'h00) &&
         (fall_cnt_reg + 8'h01 == fall_duration_reg);                // R15
   end

   // sticky copy; a new event beats a write-one clear
   always_ff @(posedge clk_i) begin
      if (rst_i) fall_sticky_reg <= 1'b0;
      else if (free_fall_event_o) fall_sticky_reg <= 1'b1;
      else if (bus_wr && bus_idx == `MSP_IDX_STATUS &&
               wb_dat_i[`MSP_ST_FALL_STICKY])
         fall_sticky_reg <= 1'b0;
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_r1_latch;
      @(posedge clk_i) disable iff (rst_i)
      (frame_sync_in_i && !sample_tick) |=> sync_latch_reg;
   endproperty
   a_r1_latch: assert property (p_r1_latch) // R1
      else $error("frame-sync pulse not latched");

   property p_r2_reload;
      @(posedge clk_i) disable iff (rst_i)
      sample_tick |=> (sync_latch_reg == $past(frame_sync_in_i)) &&
         (sync_sample_reg == ($past(sync_latch_reg) |
                              $past(frame_sync_in_i)));
   endproperty
   a_r2_reload: assert property (p_r2_reload) // R2
      else $error("frame-sync sample or reload wrong");

   property p_r3_place;
      @(posedge clk_i) disable iff (rst_i)
      (sample_tick && sync_bit_select == 3'h2) |=>
         (rotation_x_low_byte_o[0] == sync_sample_reg);
   endproperty
   a_r3_place: assert property (p_r3_place) // R3
      else $error("sync bit not placed in rotation x byte");

   property p_r4_slow;
      @(posedge clk_i) disable iff (rst_i)
      (gyro_tick && !gyro_fast) |-> ms_tick;
   endproperty
   a_r4_slow: assert property (p_r4_slow) // R4
      else $error("gyro tick off the 1 kHz grid");

   property p_r16_period;
      @(posedge clk_i) disable iff (rst_i)
      ms_tick |=> !ms_tick [*8];
   endproperty
   a_r16_period: assert property (p_r16_period) // R16
      else $error("millisecond tick too frequent");

   property p_r15_fire;
      @(posedge clk_i) disable iff (rst_i)
      (ms_tick && fall_cond && fall_duration_reg == 8'h02 &&
       fall_cnt_reg == 8'h01) |=> free_fall_event_o ##1 !free_fall_event_o;
   endproperty
   a_r15_fire: assert property (p_r15_fire) // R15
      else $error("free-fall event missing at duration");

   property p_r19_clear;
      @(posedge clk_i) disable iff (rst_i)
      (ms_tick && !fall_cond) |=> (fall_cnt_reg == 8'h00) &&
         !free_fall_event_o;
   endproperty
   a_r19_clear: assert property (p_r19_clear) // R19
      else $error("duration counter not cleared");

   property p_r20_reserved;
      @(posedge clk_i) disable iff (rst_i)
      (bus_req && !wb_we_i && bus_idx == `MSP_IDX_ROT_RANGE) |=>
         (wb_ack_o && wb_dat_o[7:5] == 3'h0 && wb_dat_o[2:0] == 3'h0);
   endproperty
   a_r20_reserved: assert property (p_r20_reserved) // R20
      else $error("reserved range bits read non-zero");

   property p_r18_reset;
      @(posedge clk_i)
      rst_i |=> (filter_sync_setup_reg == 8'h00 &&
                 fall_duration_reg == 8'h00 && rate_divider_reg == 8'h00);
   endproperty
   a_r18_reset: assert property (p_r18_reset) // R18
      else $error("configuration not zero after reset");

endmodule // msp_top

`default_nettype wire

/* verification/msp_host.sv */
/*
 Host model: classic wishbone master driving the register bus.
 Assumes ack_i is a registered one-cycle answer on clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module msp_host (
   input  wire logic        clk_i,
   input  wire logic        ack_i,
   input  wire logic [31:0] dat_i,
   output var  logic        cyc_o,
   output var  logic        stb_o,
   output var  logic        we_o,
   output var  logic [9:0]  adr_o,
   output var  logic [3:0]  sel_o,
   output var  logic [31:0] dat_o
);
   //---------------------------------------------------------------
   // bus cycles
   //---------------------------------------------------------------
   // quiet bus at time zero so no unknown request reaches the slave
   initial begin
      {cyc_o, stb_o, we_o} = 3'b000;
      adr_o = 10'h000;
      sel_o = 4'hF;
      dat_o = 32'h00000000;
   end

   // request held until ack is seen high at a rising edge
   task automatic xfer(input logic w, input logic [7:0] idx,
                       input logic [7:0] v, output logic [7:0] q);
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o  <= w;
      adr_o <= {idx, 2'b00};
      dat_o <= {24'h000000, v};
      do @(posedge clk_i); while (ack_i !== 1'b1);
      q = dat_i[7:0];
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      we_o  <= 1'b0;
      // released lines must not keep showing the old value
      adr_o <= ~adr_o;
      dat_o <= ~dat_o;
   endtask
endmodule // msp_host
`default_nettype wire

/* verification/msp_top_bench.sv */
/*
 Self-checking bench of the sensor path block.
 Assumes msp_host speaks for software on the register bus.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
   $display("wrong value at %0t: %h %h", $time, a, b); end end

module msp_top_bench;
   localparam int FAST = 10;
   localparam int MS   = 40;
   logic        clk_i, rst_i, cyc, stb, we, ack, fs, tk, ff;
   logic [9:0]  adr;
   logic [3:0]  sel;
   logic [31:0] dw, dr;
   logic [7:0]  q, tb, rxb, ryb, rzb, txb, tyb, tzb;
   logic [2:0]  lp, st;
   logic [1:0]  rr, tr;
   logic signed [15:0] ax, ay, az;
   int          n_fail = 0, checks = 0, n;
   int          lpc[3] = '{0, 1, 7};

   msp_host msp_host_i (.clk_i(clk_i), .ack_i(ack), .dat_i(dr),
      .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
      .dat_o(dw));

   // short tick counts keep the run brief
   msp_top #(.FAST_CYCLES(FAST), .MS_CYCLES(MS)) msp_top_i (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw),
      .wb_dat_o(dr), .wb_ack_o(ack), .frame_sync_in_i(fs),
      .temp_low_raw_i(8'h5A), .rotation_x_raw_i(8'hA4),
      .rotation_y_raw_i(8'h11), .rotation_z_raw_i(8'h22),
      .tilt_x_raw_i(ax), .tilt_y_raw_i(ay),
      .tilt_z_raw_i(az), .temp_low_byte_o(tb),
      .rotation_x_low_byte_o(rxb), .rotation_y_low_byte_o(ryb),
      .rotation_z_low_byte_o(rzb), .tilt_x_low_byte_o(txb),
      .tilt_y_low_byte_o(tyb), .tilt_z_low_byte_o(tzb),
      .lowpass_setting_o(lp), .rotation_range_sel_o(rr),
      .tilt_range_sel_o(tr), .axis_selftest_o(st),
      .sample_tick_o(tk), .free_fall_event_o(ff));

   //---------------------------------------------------------------
   // helpers
   //---------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   task automatic wr(input logic [7:0] i, input logic [7:0] v);
      msp_host_i.xfer(1'b1, i, v, q);
   endtask

   task automatic rd(input logic [7:0] i);
      msp_host_i.xfer(1'b0, i, 8'h00, q);
   endtask

   // cycles up to the next sample tick, bounded
   task automatic tick(output int c);
      c = 0;
      do begin @(posedge clk_i); c++; end while (tk !== 1'b1 && c < 1000);
      #1;
   endtask

   // cycles up to a free-fall event, 300 meaning none came
   task automatic ffw(output int c);
      c = 0;
      do begin @(posedge clk_i); c++; end while (ff !== 1'b1 && c < 300);
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // watchdog well beyond the few thousand cycles the tests need
   initial begin
      #800000;
      n_fail++;
      summarize();
   end

   //---------------------------------------------------------------
   // tests
   //---------------------------------------------------------------
   initial begin
      rst_i = 1'b1;
      fs = 1'b0;
      ax = 16'sh1234;
      ay = 16'sh0101;
      az = 16'shFF00;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 8'h19; i < 8'h1F; i++) begin
         rd(i[7:0]);
         `CHK(q, 8'h00)
      end
      rd(8'h33);
      `CHK(q, 8'h00)
      wr(8'h1A, 8'hFF);
      wr(8'h1B, 8'hFF);
      wr(8'h1C, 8'hFF);
      `CHK({lp, rr, tr, st}, 10'h3FF)
      rd(8'h1A);
      `CHK(q, 8'h3F)
      rd(8'h1B);
      `CHK(q, 8'h18)
      for (int i = 0; i < 8; i++) begin
         wr(8'h1C, i[7:0]);
         rd(8'h1C);
         `CHK(q, i[7:0])
      end
      $display("register test done");
      wr(8'h19, 8'h02);
      for (int i = 0; i < 3; i++) begin
         wr(8'h1A, lpc[i][7:0]);
         tick(n);
         tick(n);
         tick(n);
         `CHK(n, (lpc[i] == 1 ? MS : FAST) * 3)
      end
      $display("rate test done");
      wr(8'h19, 8'h00);
      wr(8'h1A, 8'h10);
      tick(n);
      @(posedge clk_i) fs <= 1'b1;
      @(posedge clk_i) fs <= 1'b0;
      tick(n);
      `CHK(rxb, 8'hA5)
      `CHK({tb, ryb, rzb, txb, tyb, tzb}, 48'h5A1122340100)
      tick(n);
      `CHK(rxb, 8'hA4)
      // last select code moves the sync bit to the z tilt byte
      wr(8'h1A, 8'h38);
      tick(n);
      @(posedge clk_i) fs <= 1'b1;
      @(posedge clk_i) fs <= 1'b0;
      tick(n);
      `CHK({rxb, tzb}, 16'hA401)
      $display("sync test done");
      wr(8'h1C, 8'h00);
      wr(8'h1E, 8'h02);
      ffw(n);
      `CHK(n, 300)
      wr(8'h1D, 8'h01);
      ffw(n);
      `CHK(n > MS - 4 && n < 2 * MS + 5, 1'b1)
      rd(8'h40);
      `CHK(q[1:0], 2'b11)
      wr(8'h40, 8'h01);
      wr(8'h1D, 8'h00);
      ffw(n);
      wr(8'h1D, 8'h01);
      ffw(n);
      `CHK(n > MS - 4 && n < 2 * MS + 5, 1'b1)
      // hold keeps the stored sample, so a step of 257 lsbs stays seen
      wr(8'h1C, 8'h07);
      tick(n);
      tick(n);
      @(posedge clk_i) ax <= 16'sh1335;
      tick(n);
      tick(n);
      rd(8'h40);
      `CHK(q[1], 1'b0)
      `CHK(txb, 8'h35)
      ffw(n);
      `CHK(n, 300)
      @(posedge clk_i) ax <= 16'sh1234;
      ffw(n);
      `CHK(n > MS && n < 2 * MS + 15, 1'b1)
      $display("free-fall test done");
      summarize();
   end
endmodule // msp_top_bench
`default_nettype wire
